// File: test/serial_peripheral_supervisor_tb.sv
// self-checking bench for the serial peripheral supervisor
`include "sps_consts.svh"
module serial_peripheral_supervisor_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TICK = 40;
  localparam int HWT  = 4;
  logic       clk;
  logic       rst;
  logic       app_heartbeat;
  logic       hb_en;
  logic [7:0] st;
  logic [7:0] d;
  int         fails = 0;
  int         n_checks = 0;
  int         cycles = 0;
  int         cyc;
  wire        sclk, ss_n, mosi, miso, miso_oe, app_hold, logic_reset;
  sps_supervisor #(.TICK_CYCLES(TICK), .HW_WDT_TICKS(HWT), .DEPTH(15)) i_dut (
    .clk(clk), .rst(rst), .sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
    .app_heartbeat(app_heartbeat), .app_hold(app_hold), .logic_reset(logic_reset));
  sps_master_model i_mst (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe));
  // ********
  // helpers
  // ********
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic in_range(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    check({7'h00, v >= lo && v <= hi}, 8'h01);
  endtask : in_range
  task automatic xfer(input logic [3:0] c, input logic [3:0] len, input int n);
    i_mst.tx[0] = {c, len};
    i_mst.frame(n);
    st = i_mst.rx[0];
    d = i_mst.rx[1];
  endtask : xfer
  task automatic cmd1(input logic [3:0] c, input logic [7:0] arg);
    i_mst.tx[1] = arg;
    xfer(c, 4'h1, 2);
  endtask : cmd1
  task automatic wait_hold(input logic want, input int lim);
    cyc = 0;
    while (app_hold !== want && cyc < lim)
    begin
      @(negedge clk);
      cyc++;
    end
  endtask : wait_hold
  // ********
  // scenarios
  // ********
  task automatic t_power;
    check({6'h00, app_hold, logic_reset}, 8'h03);
    wait_hold(1'b0, 200);
    check({7'h00, cyc >= TICK - 1 && cyc <= TICK + 2}, 8'h01);
    cmd1(sps_pkg::SPS_CMD_CAUSE, 8'h00);
    check(d, 8'h80);
    cmd1(sps_pkg::SPS_CMD_CAUSE, 8'h00);
    check(st, 8'h40);
    check(d, 8'h00);
    $display("test power done");
  endtask : t_power
  task automatic t_scratch;
    for (int k = 1; k < 16; k++)
      i_mst.tx[k] = 8'h13 * k[7:0] + 8'h05;
    xfer(sps_pkg::SPS_CMD_WRITE, 4'hf, 16);
    xfer(sps_pkg::SPS_CMD_READ, 4'hf, 16);
    check(st, 8'h50);
    for (int k = 1; k < 16; k++)
      check(i_mst.rx[k], 8'h13 * k[7:0] + 8'h05);
    // zero length: command byte alone must not count as short
    xfer(sps_pkg::SPS_CMD_READ, 4'h0, 1);
    cmd1(sps_pkg::SPS_CMD_LINKERR, 8'h00);
    check(st, 8'h50);
    check(d, 8'h80);
    cmd1(sps_pkg::SPS_CMD_LINKERR, 8'h00);
    check(st, 8'h40);
    check(d, 8'h00);
    $display("test scratch done");
  endtask : t_scratch
  task automatic t_link_err;
    xfer(sps_pkg::SPS_CMD_ENABLE, 4'h1, 1);
    xfer(sps_pkg::SPS_CMD_CAUSE, 4'h0, 2);
    check(st, 8'h52);
    cmd1(sps_pkg::SPS_CMD_LINKERR, 8'h00);
    check(st, 8'h50);
    check(d, 8'h28);
    $display("test link errors done");
  endtask : t_link_err
  task automatic t_refuse;
    logic [11:0] tbl [3] = '{12'h102, 12'h303, 12'hf00};
    for (int i = 0; i < 3; i++)
    begin
      cmd1(tbl[i][11:8], tbl[i][7:0]);
      xfer(sps_pkg::SPS_CMD_CAUSE, 4'h0, 1);
      check(st, 8'h42);
    end
    $display("test refuse done");
  endtask : t_refuse
  task automatic t_soft;
    cmd1(sps_pkg::SPS_CMD_TIMEOUT, 8'hff);
    cmd1(sps_pkg::SPS_CMD_ENABLE, `SPS_WDT_SW);
    cmd1(sps_pkg::SPS_CMD_REFRESH, 8'h00);
    in_range(d, 8'hf0, 8'hff);
    cmd1(sps_pkg::SPS_CMD_TIMEOUT, 8'h08);
    cmd1(sps_pkg::SPS_CMD_REFRESH, 8'h00);
    cmd1(sps_pkg::SPS_CMD_REFRESH, 8'h00);
    in_range(d, 8'h01, 8'h08);
    cmd1(sps_pkg::SPS_CMD_CAUSE, 8'h00);
    check(d, 8'h10);
    wait_hold(1'b1, 2000);
    check({6'h00, app_hold, logic_reset}, 8'h02);
    wait_hold(1'b0, 100);
    cmd1(sps_pkg::SPS_CMD_TIMEOUT, 8'h00);
    check(st, 8'h41);
    cmd1(sps_pkg::SPS_CMD_CAUSE, 8'h00);
    check(d, 8'h40);
    wait_hold(1'b1, 700);
    check({7'h00, app_hold}, 8'h00);
    $display("test soft watchdog done");
  endtask : t_soft
  task automatic t_hw;
    hb_en = 1'b1;
    cmd1(sps_pkg::SPS_CMD_ENABLE, `SPS_WDT_HW);
    wait_hold(1'b1, 10 * TICK);
    check({7'h00, app_hold}, 8'h00);
    cmd1(sps_pkg::SPS_CMD_CAUSE, 8'h00);
    check(d, 8'h20);
    cmd1(sps_pkg::SPS_CMD_RESET, `SPS_RST_SOFT);
    wait_hold(1'b1, 100);
    check({6'h00, app_hold, logic_reset}, 8'h02);
    wait_hold(1'b0, 100);
    cmd1(sps_pkg::SPS_CMD_CAUSE, 8'h00);
    check(d, 8'h60);
    hb_en = 1'b0;
    wait_hold(1'b1, (HWT + 2) * TICK);
    check({6'h00, app_hold, logic_reset}, 8'h03);
    wait_hold(1'b0, 100);
    hb_en = 1'b1;
    cmd1(sps_pkg::SPS_CMD_CAUSE, 8'h00);
    check(st, 8'h41);
    check(d, 8'h80);
    cmd1(sps_pkg::SPS_CMD_ENABLE, `SPS_WDT_BOTH);
    cmd1(sps_pkg::SPS_CMD_CAUSE, 8'h00);
    check(d, 8'h20);
    cmd1(sps_pkg::SPS_CMD_RESET, `SPS_RST_HARD);
    wait_hold(1'b1, 100);
    check({6'h00, app_hold, logic_reset}, 8'h03);
    wait_hold(1'b0, 100);
    cmd1(sps_pkg::SPS_CMD_CAUSE, 8'h00);
    check(d, 8'h80);
    $display("test hardware watchdog done");
  endtask : t_hw
  // ********
  // run control
  // ********
  task automatic results;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(negedge clk) app_heartbeat <= hb_en;
  // ceiling well above the longest expected run
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      fails++;
      results();
    end
  end
  initial
  begin
    rst = 1'b1;
    hb_en = 1'b0;
    app_heartbeat = 1'b0;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    t_power();
    t_scratch();
    t_link_err();
    t_refuse();
    t_soft();
    t_hw();
    results();
  end
endmodule : serial_peripheral_supervisor_tb
bind sps_supervisor sps_supervisor_properties #(
  .TICK_CYCLES(TICK_CYCLES), .HW_WDT_TICKS(HW_WDT_TICKS), .DEPTH(DEPTH)
) i_props (
  .clk(clk), .rst(rst), .sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
  .app_heartbeat(app_heartbeat), .app_hold(app_hold), .logic_reset(logic_reset));

// File: test/sps_master_model.sv
// link master model: frames select, clock and command bytes
module sps_master_model (
  // link
  output logic      sclk,
  output logic      ss_n,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic miso_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] tx [16];
  logic [7:0] rx [16];
  initial
  begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b1;
  end
  // clock stands still outside frames; only whole bytes are sent
  task automatic frame(input int n);
    ss_n = 1'b0;
    // half-nanosecond offset moves the link clock against the core clock edges from frame to frame
    #48.5;
    for (int b = 0; b < n && b < 16; b++)
    begin
      for (int i = 7; i >= 0; i--)
      begin
        mosi = tx[b][i];
        #24 sclk = 1'b1;
        #24 sclk = 1'b0;
        rx[b][i] = miso_oe ? miso : 1'bx;
      end
    end
    #24 ss_n = 1'b1;
    // released line must not show stale data
    mosi = ~mosi;
    #48;
  endtask : frame
endmodule : sps_master_model

// File: test/sps_supervisor_properties.sv
// port-level assertions for the serial peripheral supervisor
module sps_supervisor_properties #(
  parameter int TICK_CYCLES  = 40,
  parameter int HW_WDT_TICKS = 4,
  parameter int DEPTH        = 15
)(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // link
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  // application
  input wire logic app_heartbeat,
  input wire logic app_hold,
  input wire logic logic_reset
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HOLD_LO = TICK_CYCLES - 1;
  localparam int HOLD_HI = TICK_CYCLES + 2;
  logic [15:0] hold_cnt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // ********
  // helpers
  // ********
  // power-up hold runs one cycle longer, hence the slack
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      hold_cnt <= 16'h0000;
    else if (!app_hold)
      hold_cnt <= 16'h0000;
    else
      hold_cnt <= hold_cnt + 16'h0001;
  end
  sequence s_hold_begin;
    $rose(app_hold);
  endsequence
  sequence s_hold_end;
    ##[HOLD_LO:HOLD_HI] $fell(app_hold);
  endsequence
  // ********
  // assertions
  // ********
  hold_len_a: assert property (s_hold_begin |-> s_hold_end)
    else $error("hold length wrong");
  hold_bound_a: assert property (hold_cnt <= HOLD_HI)
    else $error("hold too long");
  hard_in_hold_a: assert property (logic_reset |-> app_hold)
    else $error("logic reset outside hold");
  hard_start_a: assert property ($rose(logic_reset) |-> $rose(app_hold))
    else $error("hard reset not with hold");
  soft_keeps_a: assert property (s_hold_begin ##0 !logic_reset |=> !logic_reset [*8])
    else $error("soft reset touched logic");
  oe_idle_a: assert property (ss_n |-> !miso_oe)
    else $error("drive while deselected");
  oe_start_a: assert property ($rose(miso_oe) |-> !ss_n)
    else $error("drive without select");
  miso_step_a: assert property (miso_oe && $changed(miso) |-> $rose(sclk) && !ss_n)
    else $error("miso moved off clock");
endmodule : sps_supervisor_properties

// File: verilog/sps_consts.svh
// constants for the serial peripheral supervisor: timing, field positions, reset values
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH

// ****************************************
// timing
// ****************************************
`define SPS_CLK_MHZ        250
`define SPS_STEP_MS        25
`define SPS_TICK_CYCLES    (`SPS_STEP_MS * 1000 * `SPS_CLK_MHZ)
`define SPS_HW_WDT_TICKS   64
`define SPS_MAX_PAYLOAD    15
`define SPS_REQ_BIT        3'h3
`define SPS_LAST_BIT       3'h7

// ****************************************
// field positions
// ****************************************
`define SPS_CAUSE_HW_RST   7
`define SPS_CAUSE_SW_RST   6
`define SPS_CAUSE_HW_EN    5
`define SPS_CAUSE_SW_EN    4
`define SPS_ERR_RX_AVAIL   7
`define SPS_ERR_COLLIDE    6
`define SPS_ERR_OVERRUN    5
`define SPS_ERR_FAULT      4
`define SPS_ERR_COMPARE    3

// ****************************************
// argument codes and reset values
// ****************************************
`define SPS_RST_HARD       8'h00
`define SPS_RST_SOFT       8'h01
`define SPS_WDT_BOTH       8'h00
`define SPS_WDT_HW         8'h01
`define SPS_WDT_SW         8'h02
`define SPS_CAUSE_HW_INIT  1'b1
`define SPS_ERR_INIT       5'h00

`endif

// File: verilog/sps_pkg.sv
// types shared by the serial peripheral supervisor
package sps_pkg;

  typedef enum logic [3:0] {
    SPS_CMD_RESET   = 4'h1,
    SPS_CMD_TIMEOUT = 4'h2,
    SPS_CMD_ENABLE  = 4'h3,
    SPS_CMD_REFRESH = 4'h4,
    SPS_CMD_CAUSE   = 4'h5,
    SPS_CMD_LINKERR = 4'h6,
    SPS_CMD_WRITE   = 4'h7,
    SPS_CMD_READ    = 4'h8
  } sps_cmd_type;

  typedef enum logic [1:0] {
    SPS_PH_RUN  = 2'b00,
    SPS_PH_HARD = 2'b01,
    SPS_PH_SOFT = 2'b10
  } sps_phase_type;

  typedef enum logic [1:0] {
    SPS_ST_RSVD  = 2'b00,
    SPS_ST_READY = 2'b01,
    SPS_ST_BUSY  = 2'b10,
    SPS_ST_GONE  = 2'b11
  } sps_state_type;

  typedef struct packed {
    sps_state_type state;
    logic          router;
    logic          comm_err;
    logic [1:0]    rsvd;
    logic          unexec;
    logic          expired;
  } sps_status_type;

endpackage : sps_pkg

// File: verilog/sps_supervisor.sv
// serial peripheral supervisor: link shifter, command decode, watchdogs and reset control
// ****************************************
// How it works
// - transfers carry zero to fifteen payload bytes; length field is four bits
// - zero length means the command byte alone, no data bytes
// - after any reset the application resumes one 25 ms step later
// - reset argument 0 resets all logic, 1 only the processor
// - soft watchdog timeout is 0.025 to 6.375 s in 25 ms steps
// - timeout value zero disables the soft watchdog
// - enable argument 0 both, 1 hardware only, 2 soft only
// - hardware watchdog stays enabled until a hard reset
// - hardware watchdog expiry forces a hard reset
// - soft watchdog expiry without refresh forces a soft reset
// - refresh returns the present count, count times 25 ms remains
// - reset cause byte: hard, soft, hardware enable, soft enable, low bits zero
// - reading the link error byte clears it; reading reset cause clears its hard and soft bits
// - link error bits: data waiting, write collision, overrun
// - link error bits: mode fault, compare error, low bits zero
// - each frame returns the status of the previous command
// - status state field ready while running, busy during a reset hold, never absent; bit 5 zero for device
// - status bit 4 set while any link error flag is set
// - status bit 1 set when the last command was not executed
// - status bit 0 set after either watchdog expired
// - full duplex while select is held, frame ends with select
// ****************************************
`include "sps_consts.svh"

module sps_supervisor #(
  parameter int TICK_CYCLES  = `SPS_TICK_CYCLES,
  parameter int HW_WDT_TICKS = `SPS_HW_WDT_TICKS,
  parameter int DEPTH        = `SPS_MAX_PAYLOAD
)(
  // core clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // serial link, clocked by the master
  input  wire logic sclk,
  input  wire logic ss_n,
  input  wire logic mosi,
  output logic      miso,
  output logic      miso_oe,
  // application side
  input  wire logic app_heartbeat,
  output logic      app_hold,
  output logic      logic_reset
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int HW = $clog2(HW_WDT_TICKS + 1);

  // ****************************************
  // link domain
  // ****************************************
  logic       link_rst;
  logic [2:0] bit_cnt;
  logic [6:0] rx_shift;
  logic [6:0] tx_shift;
  logic [7:0] rx_hold;
  logic [3:0] nib_hold;
  logic       req_tgl;
  logic       done_tgl;
  logic [7:0] tx_word;

  // select released ends the frame; the link clock may stop, so nothing waits for an edge
  assign link_rst = rst | ss_n;

  always_ff @(posedge sclk or posedge link_rst)
  begin
    if (link_rst)
    begin
      bit_cnt  <= 3'h0;
      rx_shift <= 7'h00;
    end
    else
    begin
      bit_cnt  <= bit_cnt + 3'h1;
      rx_shift <= {rx_shift[5:0], mosi};
    end
  end

  always_ff @(posedge sclk or posedge link_rst)
  begin
    if (link_rst)
    begin
      miso     <= 1'b0;
      miso_oe  <= 1'b0;
      tx_shift <= 7'h00;
    end
    else if (bit_cnt == 3'h0)
    begin
      miso     <= tx_word[7];
      miso_oe  <= 1'b1;
      tx_shift <= tx_word[6:0];
    end
    else
    begin
      miso     <= tx_shift[6];
      tx_shift <= {tx_shift[5:0], 1'b0};
    end
  end

  // toggles survive the frame so the core never misses an event
  always_ff @(posedge sclk or posedge rst)
  begin
    if (rst)
    begin
      nib_hold <= 4'h0;
      rx_hold  <= 8'h00;
      req_tgl  <= 1'b0;
      done_tgl <= 1'b0;
    end
    else if (!ss_n && bit_cnt == `SPS_REQ_BIT)
    begin
      nib_hold <= {rx_shift[2:0], mosi};
      req_tgl  <= ~req_tgl;
    end
    else if (!ss_n && bit_cnt == `SPS_LAST_BIT)
    begin
      rx_hold  <= {rx_shift, mosi};
      done_tgl <= ~done_tgl;
    end
  end

  // ****************************************
  // crossings into the core
  // ****************************************
  logic [2:0] ss_sy;
  logic [2:0] req_sy;
  logic [2:0] done_sy;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ss_sy   <= 3'h0;
      req_sy  <= 3'h0;
      done_sy <= 3'h0;
    end
    else
    begin
      ss_sy   <= {ss_sy[1:0], ~ss_n};
      req_sy  <= {req_sy[1:0], req_tgl};
      done_sy <= {done_sy[1:0], done_tgl};
    end
  end

  logic frame_on;
  logic frame_end;
  logic req_ev;
  logic done_ev;
  assign frame_on  = ss_sy[1];
  assign frame_end = ss_sy[2] & ~ss_sy[1];
  assign req_ev    = req_sy[2] ^ req_sy[1];
  assign done_ev   = done_sy[2] ^ done_sy[1];

  // ****************************************
  // core state
  // ****************************************
  sps_pkg::sps_phase_type  phase;
  sps_pkg::sps_cmd_type    cmd;
  sps_pkg::sps_status_type status;
  logic [3:0]    len;
  logic [4:0]    idx;
  logic          pend_req;
  logic          executed;
  logic [7:0]    mem [DEPTH];
  logic [TW-1:0] tick_cnt;
  logic [HW-1:0] hw_cnt;
  logic [7:0]    sw_timeout;
  logic [7:0]    sw_count;
  logic          sw_en;
  logic          hw_en;
  logic          cause_hw;
  logic          cause_sw;
  logic          wdt_expired;
  logic          last_unexec;
  logic [7:3]    link_err;

  // ****************************************
  // command decode
  // ****************************************
  function automatic logic cmd_ok(input sps_pkg::sps_cmd_type c, input logic [3:0] n, input logic [7:0] a);
    logic ok;
    ok = 1'b0;
    case (c)
      sps_pkg::SPS_CMD_RESET:   ok = (n == 4'h1) && (a <= `SPS_RST_SOFT);
      sps_pkg::SPS_CMD_TIMEOUT: ok = (n == 4'h1);
      sps_pkg::SPS_CMD_ENABLE:  ok = (n == 4'h1) && (a <= `SPS_WDT_SW);
      sps_pkg::SPS_CMD_REFRESH: ok = (n <= 4'h1);
      sps_pkg::SPS_CMD_CAUSE:   ok = (n <= 4'h1);
      sps_pkg::SPS_CMD_LINKERR: ok = (n <= 4'h1);
      sps_pkg::SPS_CMD_WRITE:   ok = 1'b1;
      sps_pkg::SPS_CMD_READ:    ok = 1'b1;
      default:                  ok = 1'b0;
    endcase
    return ok;
  endfunction : cmd_ok

  sps_pkg::sps_cmd_type ex_cmd;
  sps_pkg::sps_cmd_type nib_cmd;
  logic [3:0] ex_len;
  logic       exec_go;
  logic       exec_ok;
  logic       tick;
  logic       sw_expire;
  logic       hw_expire;
  logic       hard_go;
  logic       soft_go;
  logic       rd_cause;
  logic       rd_link;
  logic [7:3] err_set;

  assign nib_cmd = sps_pkg::sps_cmd_type'(nib_hold);
  assign ex_cmd  = (idx == 5'h00) ? sps_pkg::sps_cmd_type'(rx_hold[7:4]) : cmd;
  assign ex_len  = (idx == 5'h00) ? rx_hold[3:0] : len;
  // the command runs on its last byte; a zero length runs on the command byte itself
  assign exec_go = frame_on & done_ev & (({1'b0, ex_len} == idx) | ((idx == 5'h00) & (rx_hold[3:0] == 4'h0)));
  assign exec_ok = exec_go & (phase == sps_pkg::SPS_PH_RUN) & cmd_ok(ex_cmd, ex_len, rx_hold);

  assign hard_go = (exec_ok & (ex_cmd == sps_pkg::SPS_CMD_RESET) & (rx_hold == `SPS_RST_HARD)) | hw_expire;
  assign soft_go = (exec_ok & (ex_cmd == sps_pkg::SPS_CMD_RESET) & (rx_hold == `SPS_RST_SOFT)) | sw_expire;

  // byte 0 carries the command nibble; its answer is prepared mid-byte
  assign rd_cause = frame_on & req_ev & (idx == 5'h00) & (nib_cmd == sps_pkg::SPS_CMD_CAUSE);
  assign rd_link  = frame_on & req_ev & (idx == 5'h00) & (nib_cmd == sps_pkg::SPS_CMD_LINKERR);

  always_comb
  begin
    err_set = 5'h00;
    err_set[`SPS_ERR_RX_AVAIL] = frame_on & done_ev & (idx != 5'h00) & (cmd == sps_pkg::SPS_CMD_WRITE);
    err_set[`SPS_ERR_COLLIDE]  = frame_on & done_ev & ~pend_req & ~req_ev;
    err_set[`SPS_ERR_OVERRUN]  = frame_on & done_ev & (idx != 5'h00) & (idx > {1'b0, len});
    err_set[`SPS_ERR_FAULT]    = frame_end & pend_req;
    err_set[`SPS_ERR_COMPARE]  = frame_end & (idx != 5'h00) & ~executed;
  end

  // ****************************************
  // transaction tracking and answer words
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      idx      <= 5'h00;
      cmd      <= sps_pkg::SPS_CMD_RESET;
      len      <= 4'h0;
      pend_req <= 1'b0;
      executed <= 1'b0;
    end
    else if (!frame_on)
    begin
      idx      <= 5'h00;
      pend_req <= 1'b0;
      executed <= 1'b0;
    end
    else
    begin
      if (req_ev)
        pend_req <= 1'b1;
      else if (done_ev)
        pend_req <= 1'b0;
      if (done_ev)
      begin
        if (idx != 5'h1f)
          idx <= idx + 5'h01;
        if (idx == 5'h00)
        begin
          cmd <= sps_pkg::sps_cmd_type'(rx_hold[7:4]);
          len <= rx_hold[3:0];
        end
      end
      if (exec_go)
        executed <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (frame_on && done_ev && cmd == sps_pkg::SPS_CMD_WRITE && idx != 5'h00 && idx <= {1'b0, len}
        && phase == sps_pkg::SPS_PH_RUN)
      mem[4'(idx - 5'h01)] <= rx_hold;
  end

  // outside a frame the word to send is the status of the command before
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tx_word <= 8'h00;
    else if (!frame_on)
      tx_word <= status;
    else if (req_ev)
    begin
      case ((idx == 5'h00) ? nib_cmd : cmd)
        sps_pkg::SPS_CMD_REFRESH: tx_word <= sw_count;
        sps_pkg::SPS_CMD_CAUSE:   tx_word <= {cause_hw, cause_sw, hw_en, sw_en, 4'h0};
        sps_pkg::SPS_CMD_LINKERR: tx_word <= {link_err, 3'h0};
        sps_pkg::SPS_CMD_READ:    tx_word <= (idx < 5'(DEPTH)) ? mem[4'(idx)] : 8'h00;
        default:                  tx_word <= 8'h00;
      endcase
    end
  end

  always_comb
  begin
    status.state    = (phase == sps_pkg::SPS_PH_RUN) ? sps_pkg::SPS_ST_READY : sps_pkg::SPS_ST_BUSY;
    status.router   = 1'b0;
    status.comm_err = |link_err;
    status.rsvd     = 2'h0;
    status.unexec   = last_unexec;
    status.expired  = wdt_expired;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      last_unexec <= 1'b0;
    else if (exec_go)
      last_unexec <= ~exec_ok;
    else if (frame_end && idx != 5'h00 && !executed)
      last_unexec <= 1'b1;
  end

  // ****************************************
  // tick, reset phase and outputs
  // ****************************************
  assign tick = (tick_cnt == TW'(TICK_CYCLES - 1));

  // the step restarts on every reset so the hold lasts one whole step
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tick_cnt <= '0;
    else if (tick || hard_go || soft_go)
      tick_cnt <= '0;
    else
      tick_cnt <= tick_cnt + TW'(1);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      phase <= sps_pkg::SPS_PH_HARD;
    else if (hard_go)
      phase <= sps_pkg::SPS_PH_HARD;
    else if (soft_go)
      phase <= sps_pkg::SPS_PH_SOFT;
    else
    begin
      case (phase)
        sps_pkg::SPS_PH_RUN:  phase <= sps_pkg::SPS_PH_RUN;
        sps_pkg::SPS_PH_HARD: phase <= tick ? sps_pkg::SPS_PH_RUN : sps_pkg::SPS_PH_HARD;
        sps_pkg::SPS_PH_SOFT: phase <= tick ? sps_pkg::SPS_PH_RUN : sps_pkg::SPS_PH_SOFT;
        default:              phase <= sps_pkg::SPS_PH_RUN;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      app_hold    <= 1'b1;
      logic_reset <= 1'b1;
    end
    else
    begin
      app_hold    <= (phase != sps_pkg::SPS_PH_RUN);
      logic_reset <= (phase == sps_pkg::SPS_PH_HARD);
    end
  end

  // ****************************************
  // watchdogs
  // ****************************************
  assign sw_expire = tick & sw_en & (sw_timeout != 8'h00) & (sw_count <= 8'h01)
                     & (phase == sps_pkg::SPS_PH_RUN);
  assign hw_expire = tick & hw_en & (hw_cnt == HW'(HW_WDT_TICKS - 1)) & (phase == sps_pkg::SPS_PH_RUN);

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sw_timeout <= 8'h00;
      sw_count   <= 8'h00;
      sw_en      <= 1'b0;
    end
    else if (hard_go)
    begin
      sw_timeout <= 8'h00;
      sw_count   <= 8'h00;
      sw_en      <= 1'b0;
    end
    else if (exec_ok && ex_cmd == sps_pkg::SPS_CMD_TIMEOUT)
    begin
      sw_timeout <= rx_hold;
      sw_count   <= rx_hold;
      if (rx_hold == 8'h00)
        sw_en <= 1'b0;
    end
    else if (exec_ok && ex_cmd == sps_pkg::SPS_CMD_ENABLE && rx_hold != `SPS_WDT_HW)
    begin
      sw_en    <= (sw_timeout != 8'h00);
      sw_count <= sw_timeout;
    end
    else if (exec_ok && ex_cmd == sps_pkg::SPS_CMD_REFRESH)
      sw_count <= sw_timeout;
    else if (sw_expire)
      sw_count <= sw_timeout;
    else if (tick && sw_en && sw_count != 8'h00 && phase == sps_pkg::SPS_PH_RUN)
      sw_count <= sw_count - 8'h01;
  end

  // the heartbeat stands for the card keeping its own watchdog fed
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      hw_en  <= 1'b0;
      hw_cnt <= '0;
    end
    else if (hard_go)
    begin
      hw_en  <= 1'b0;
      hw_cnt <= '0;
    end
    else
    begin
      if (exec_ok && ex_cmd == sps_pkg::SPS_CMD_ENABLE && rx_hold != `SPS_WDT_SW)
        hw_en <= 1'b1;
      if (app_heartbeat || !hw_en || phase != sps_pkg::SPS_PH_RUN)
        hw_cnt <= '0;
      else if (tick)
        hw_cnt <= hw_cnt + HW'(1);
    end
  end

  // ****************************************
  // clear-on-read flags, a set beats a clear
  // ****************************************
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cause_hw    <= `SPS_CAUSE_HW_INIT;
      cause_sw    <= 1'b0;
      wdt_expired <= 1'b0;
    end
    else
    begin
      if (hard_go)
        cause_hw <= 1'b1;
      else if (rd_cause)
        cause_hw <= 1'b0;
      if (soft_go && !hard_go)
        cause_sw <= 1'b1;
      else if (rd_cause)
        cause_sw <= 1'b0;
      if (hw_expire || sw_expire)
        wdt_expired <= 1'b1;
      else if (rd_cause)
        wdt_expired <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      link_err <= `SPS_ERR_INIT;
    else if (hard_go)
      link_err <= err_set;
    else if (rd_link)
      link_err <= err_set;
    else
      link_err <= link_err | err_set;
  end

endmodule : sps_supervisor
